// [hdl/servo_regs.svh]
`ifndef SERVO_REGS_SVH
`define SERVO_REGS_SVH

// System clock rate and PWM carrier default
`define CLK_HZ          25000000
`define PWM_FREQ_HZ     20000
`define PWM_PERIOD_RST  12'((`CLK_HZ) / (`PWM_FREQ_HZ))

// Register byte addresses
`define ADR_PWM_PERIOD  8'h00
`define ADR_STALL_TMO   8'h04
`define ADR_STATUS      8'h08
`define ADR_MEASURE     8'h0c
`define ADR_IRQ_STAT    8'h10
`define ADR_IRQ_MASK    8'h14

// Interrupt bit positions
`define IRQ_LOCK_ON     0
`define IRQ_LOCK_OFF    1
`define IRQ_LOCKOUT     2
`define IRQ_OVERCUR     3

// Speed servo constants, in reference clock ticks
`define REF_DIV         16'h2000
`define REF_DIV2        17'h04000
`define LOCK_WIN        16'h0200
`define PERIOD_MAX      16'hffff

// Duty steps of the charge-pump style updates
`define PLL_STEP        14'h0004
`define DISC_STEP       14'h0010
`define OC_STEP         14'h0008

// Reset values
`define DUTY_RST        12'h000
`define IRQ_MASK_RST    4'h0
`define STALL_TMO_DEF   32'h016e3600

`endif

// [hdl/servo_pkg.sv]
package servo_pkg;

    // Control states, one-hot
    typedef enum logic [2:0]
    {
        ST_STOP    = 3'b001,
        ST_RUN     = 3'b010,
        ST_LOCKOUT = 3'b100
    } state_e;

    // Pin inputs gathered for synchronising
    typedef struct packed
    {
        logic       osc;
        logic       tacho;
        logic [2:0] hall;
        logic       dir_rev;
        logic       stop;
        logic       over_current;
        logic       stall_en;
    } pin_in_s;

    // High-side and low-side switch drives, bit 0 is phase a
    typedef struct packed
    {
        logic [2:0] high;
        logic [2:0] low;
    } phase_drive_s;

endpackage : servo_pkg

// [hdl/bit_sync.sv]
`timescale 1ns/10ps

module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    // Two flops per bit, first read only by second
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : bit_sync

// [hdl/pwm_carrier.sv]
`timescale 1ns/10ps

module pwm_carrier (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [11:0] period,
    input  wire logic [11:0] duty,
    output logic             on,
    output logic             start
);

    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic        on_d;
    logic        start_d;

    // Carrier counter, wraps at period, on while below duty
    always_comb
    begin
        start_d = (cnt_q + 12'h001 >= period);
        cnt_d   = start_d ? 12'h000 : cnt_q + 12'h001;
        on_d    = (cnt_d < duty);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 12'h000;
            on    <= 1'b0;
            start <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            on    <= on_d;
            start <= start_d;
        end
    end

endmodule : pwm_carrier

// [hdl/bldc_speed_servo_protect.sv]
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "servo_regs.svh"

module bldc_speed_servo_protect #(
    parameter logic [31:0] STALL_TMO_DEFAULT = `STALL_TMO_DEF
) (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic [7:0]              addr,
    input  wire logic [31:0]             wdata,
    input  wire logic                    we,
    input  wire logic                    re,
    output logic      [31:0]             rdata,
    input  wire logic                    osc_in,
    input  wire logic                    tacho_pulse,
    input  wire logic                    hall_a,
    input  wire logic                    hall_b,
    input  wire logic                    hall_c,
    input  wire logic                    dir_rev,
    input  wire logic                    stop_req,
    input  wire logic                    over_current,
    input  wire logic                    stall_timer_input,
    output servo_pkg::phase_drive_s      drive,
    output logic                         speed_locked_n_o,
    output logic                         speed_locked_n_oe,
    output logic                         irq
);

    servo_pkg::pin_in_s     pins_raw;
    servo_pkg::pin_in_s     pins_s;
    servo_pkg::state_e      state_q, state_d;
    servo_pkg::phase_drive_s drive_d;

    logic        osc_prev_q, osc_prev_d;
    logic        tach_prev_q, tach_prev_d;
    logic [12:0] ref_div_q, ref_div_d;
    logic [15:0] per_cnt_q, per_cnt_d;
    logic [15:0] per_q, per_d;
    logic [15:0] prev_per_q, prev_per_d;
    logic        half_q, half_d;
    logic        locked_q, locked_d;
    logic [11:0] duty_q, duty_d;
    logic        oc_cut_q, oc_cut_d;
    logic [31:0] stall_cnt_q, stall_cnt_d;
    logic        dir_prev_q, dir_prev_d;
    logic        rev_q, rev_d;
    logic [11:0] pwm_period_q, pwm_period_d;
    logic [31:0] stall_tmo_q, stall_tmo_d;
    logic [3:0]  irq_stat_q, irq_stat_d;
    logic [3:0]  irq_mask_q, irq_mask_d;
    logic [31:0] rdata_d;

    logic        ref_tick, tach_tick;
    logic        pwm_on, pwm_start;
    logic [15:0] diff;
    logic [16:0] sum2;
    logic [13:0] acc;
    logic [3:0]  events;
    logic [2:0]  code;
    logic [2:0]  src, sink;
    logic        brake;

    // Gather pins for synchronising; osc_in at most 10 MHz is caught by 25 MHz sampling
    assign pins_raw = '{osc: osc_in, tacho: tacho_pulse, hall: {hall_a, hall_b, hall_c},
                        dir_rev: dir_rev, stop: stop_req, over_current: over_current,
                        stall_en: stall_timer_input};

    bit_sync #(
        .WIDTH ($bits(servo_pkg::pin_in_s))
    ) u_sync (
        .clock (clock),
        .rst   (rst),
        .d     (pins_raw),
        .q     (pins_s)
    );

    // Carrier with software period
    pwm_carrier u_pwm (
        .clock  (clock),
        .rst    (rst),
        .period (pwm_period_q),
        .duty   (duty_q),
        .on     (pwm_on),
        .start  (pwm_start)
    );

    // Speed servo: period measure, discriminator, phase loop, duty integrator
    always_comb
    begin
        ref_tick     = pins_s.osc & ~osc_prev_q;
        tach_tick    = pins_s.tacho & ~tach_prev_q;
        osc_prev_d   = pins_s.osc;
        tach_prev_d  = pins_s.tacho;
        ref_div_d    = ref_div_q + {12'h000, ref_tick};           // Wraps every 8192 ticks
        per_cnt_d    = per_cnt_q;
        per_d        = per_q;
        prev_per_d   = prev_per_q;
        half_d       = half_q;
        locked_d     = locked_q;
        oc_cut_d     = oc_cut_q;
        acc          = {2'b00, duty_q};
        diff         = (per_cnt_q > `REF_DIV) ? per_cnt_q - `REF_DIV : `REF_DIV - per_cnt_q;
        sum2         = {1'b0, prev_per_q} + {1'b0, per_cnt_q};
        if (ref_tick && per_cnt_q != `PERIOD_MAX)
        begin
            per_cnt_d = per_cnt_q + 16'h0001;
        end
        if (tach_tick)
        begin
            per_cnt_d  = 16'h0000;
            per_d      = per_cnt_q;
            prev_per_d = per_cnt_q;
            half_d     = ~half_q;
            locked_d   = (diff <= `LOCK_WIN);                      // 512 of 8192 ticks
            // Phase error each period: late edge speeds up
            if (!ref_div_q[12])
            begin
                acc = acc + `PLL_STEP;
            end
            else if (acc >= `PLL_STEP)
            begin
                acc = acc - `PLL_STEP;
            end
            // Speed error every second period, used out of lock
            if (half_q && !locked_d)
            begin
                if (sum2 > `REF_DIV2)
                begin
                    acc = acc + `DISC_STEP;
                end
                else if (acc >= `DISC_STEP)
                begin
                    acc = acc - `DISC_STEP;
                end
            end
        end
        else if (per_cnt_q > `REF_DIV + `LOCK_WIN)
        begin
            locked_d = 1'b0;                                       // Too slow or stalled
        end
        // Overcurrent lowers duty and cuts the rest of the carrier cycle
        if (pwm_start)
        begin
            oc_cut_d = 1'b0;
            if (pins_s.over_current && acc >= `OC_STEP)
            begin
                acc = acc - `OC_STEP;
            end
        end
        if (pins_s.over_current)
        begin
            oc_cut_d = 1'b1;
        end
        if (acc > {2'b00, pwm_period_q})
        begin
            acc = {2'b00, pwm_period_q};
        end
        duty_d = acc[11:0];
        // Stop restarts control from unlocked and idle
        if (state_q == servo_pkg::ST_STOP)
        begin
            per_cnt_d = 16'h0000;
            half_d    = 1'b0;
            locked_d  = 1'b0;
            duty_d    = `DUTY_RST;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            osc_prev_q  <= 1'b0;
            tach_prev_q <= 1'b0;
            ref_div_q   <= 13'h0000;
            per_cnt_q   <= 16'h0000;
            per_q       <= 16'h0000;
            prev_per_q  <= 16'h0000;
            half_q      <= 1'b0;
            locked_q    <= 1'b0;
            duty_q      <= `DUTY_RST;
            oc_cut_q    <= 1'b0;
        end
        else
        begin
            osc_prev_q  <= osc_prev_d;
            tach_prev_q <= tach_prev_d;
            ref_div_q   <= ref_div_d;
            per_cnt_q   <= per_cnt_d;
            per_q       <= per_d;
            prev_per_q  <= prev_per_d;
            half_q      <= half_d;
            locked_q    <= locked_d;
            duty_q      <= duty_d;
            oc_cut_q    <= oc_cut_d;
        end
    end

    // Start/stop, stall lock-out timer and reversal tracking
    always_comb
    begin
        state_d     = state_q;
        stall_cnt_d = stall_cnt_q;
        dir_prev_d  = pins_s.dir_rev;
        rev_d       = rev_q;
        case (state_q)
            servo_pkg::ST_STOP:
            begin
                stall_cnt_d = 32'h0000_0000;
                rev_d       = 1'b0;
                if (!pins_s.stop)
                begin
                    state_d = servo_pkg::ST_RUN;
                end
            end
            servo_pkg::ST_RUN:
            begin
                if (pins_s.dir_rev != dir_prev_q)
                begin
                    rev_d = 1'b1;
                end
                else if (locked_q)
                begin
                    rev_d = 1'b0;
                end
                // Timer restarts on lock; grounded timer input disables it
                if (locked_q || !pins_s.stall_en)
                begin
                    stall_cnt_d = 32'h0000_0000;
                end
                else if (ref_tick)
                begin
                    stall_cnt_d = stall_cnt_q + 32'h0000_0001;
                end
                if (pins_s.stop)
                begin
                    state_d = servo_pkg::ST_STOP;
                end
                else if (pins_s.stall_en && stall_tmo_q != 32'h0000_0000 && stall_cnt_q >= stall_tmo_q)
                begin
                    state_d = servo_pkg::ST_LOCKOUT;
                end
            end
            servo_pkg::ST_LOCKOUT:
            begin
                if (pins_s.stop)
                begin
                    state_d = servo_pkg::ST_STOP;                 // Only exit
                end
            end
            default:
            begin
                state_d = servo_pkg::ST_STOP;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q     <= servo_pkg::ST_STOP;
            stall_cnt_q <= 32'h0000_0000;
            dir_prev_q  <= 1'b0;
            rev_q       <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            stall_cnt_q <= stall_cnt_d;
            dir_prev_q  <= dir_prev_d;
            rev_q       <= rev_d;
        end
    end

    // Commutation: reverse uses inverted Hall code
    always_comb
    begin
        code    = pins_s.dir_rev ? ~pins_s.hall : pins_s.hall;
        brake   = rev_q & pins_s.over_current;
        src     = 3'h0;
        sink    = 3'h0;
        case (code)
            3'b101:  begin src = 3'b010; sink = 3'b001; end
            3'b100:  begin src = 3'b100; sink = 3'b001; end
            3'b110:  begin src = 3'b100; sink = 3'b010; end
            3'b010:  begin src = 3'b001; sink = 3'b010; end
            3'b011:  begin src = 3'b001; sink = 3'b100; end
            3'b001:  begin src = 3'b010; sink = 3'b100; end
            default: begin src = 3'h0;   sink = 3'h0;   end
        endcase
        drive_d = '{high: 3'h0, low: 3'h0};
        if (state_q == servo_pkg::ST_RUN)                          // Stop, lock-out: all off
        begin
            if (brake)
            begin
                drive_d = '{high: 3'b111, low: 3'h0};              // Short brake
            end
            else
            begin
                // Source fully on, sink chopped by PWM
                drive_d = '{high: src, low: (pwm_on && !oc_cut_q) ? sink : 3'h0};
            end
        end
    end

    // Register file and interrupt status
    always_comb
    begin
        events                = 4'h0;
        events[`IRQ_LOCK_ON]  = locked_d & ~locked_q;
        events[`IRQ_LOCK_OFF] = ~locked_d & locked_q;
        events[`IRQ_LOCKOUT]  = (state_d == servo_pkg::ST_LOCKOUT) && (state_q != servo_pkg::ST_LOCKOUT);
        events[`IRQ_OVERCUR]  = pwm_start & pins_s.over_current;
        pwm_period_d = pwm_period_q;
        stall_tmo_d  = stall_tmo_q;
        irq_mask_d   = irq_mask_q;
        irq_stat_d   = irq_stat_q;
        rdata_d      = 32'h0000_0000;
        if (we && addr == `ADR_PWM_PERIOD)
        begin
            pwm_period_d = wdata[11:0];
        end
        else if (we && addr == `ADR_STALL_TMO)
        begin
            stall_tmo_d = wdata;
        end
        else if (we && addr == `ADR_IRQ_STAT)
        begin
            irq_stat_d = irq_stat_q & ~wdata[3:0];
        end
        else if (we && addr == `ADR_IRQ_MASK)
        begin
            irq_mask_d = wdata[3:0];
        end
        irq_stat_d = irq_stat_d | events;                         // Set wins over clear
        if (re && addr == `ADR_PWM_PERIOD)
        begin
            rdata_d = {20'h00000, pwm_period_q};
        end
        else if (re && addr == `ADR_STALL_TMO)
        begin
            rdata_d = stall_tmo_q;
        end
        else if (re && addr == `ADR_STATUS)
        begin
            rdata_d = {duty_q, 15'h0000, rev_q, locked_q, state_q};
        end
        else if (re && addr == `ADR_MEASURE)
        begin
            rdata_d = {16'h0000, per_q};
        end
        else if (re && addr == `ADR_IRQ_STAT)
        begin
            rdata_d = {28'h0000000, irq_stat_q};
        end
        else if (re && addr == `ADR_IRQ_MASK)
        begin
            rdata_d = {28'h0000000, irq_mask_q};
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pwm_period_q      <= `PWM_PERIOD_RST;
            stall_tmo_q       <= STALL_TMO_DEFAULT;
            irq_mask_q        <= `IRQ_MASK_RST;
            irq_stat_q        <= 4'h0;
            rdata             <= 32'h0000_0000;
            drive             <= '{high: 3'h0, low: 3'h0};
            speed_locked_n_oe <= 1'b0;
            irq               <= 1'b0;
        end
        else
        begin
            pwm_period_q      <= pwm_period_d;
            stall_tmo_q       <= stall_tmo_d;
            irq_mask_q        <= irq_mask_d;
            irq_stat_q        <= irq_stat_d;
            rdata             <= rdata_d;
            drive             <= drive_d;
            speed_locked_n_oe <= locked_q;                         // Pull low while locked
            irq               <= |(irq_stat_d & irq_mask_d);
        end
    end

    // Open-collector pin only ever drives low
    assign speed_locked_n_o = 1'b0;

endmodule : bldc_speed_servo_protect

// [dv/servo_monitor.sv]
`timescale 1ns/10ps

module servo_monitor (
    input wire logic                    clock,
    input wire logic                    rst,
    input wire logic                    hall_a,
    input wire logic                    hall_b,
    input wire logic                    hall_c,
    input wire logic                    stop_req,
    input wire logic                    over_current,
    input wire servo_pkg::phase_drive_s drive,
    input wire logic                    speed_locked_n_o,
    input wire logic                    speed_locked_n_oe,
    input wire logic                    irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Drive and lock pin relations
    a_lock_pin_low: assert property (speed_locked_n_o == 1'b0)
        else $error("lock pin driven high");
    a_no_shoot: assert property ((drive.high & drive.low) == 3'h0)
        else $error("both switches of a phase on");
    a_one_sink: assert property ($onehot0(drive.low))
        else $error("more than one low side on");
    a_one_source: assert property (drive.high != 3'h7 |-> $onehot0(drive.high))
        else $error("more than one high side on");
    a_stop_off: assert property (stop_req [*6] |-> drive == 6'h00)
        else $error("drive on while stopped");
    a_overcur_low: assert property (over_current [*6] |-> drive.low == 3'h0)
        else $error("low side on during overcurrent");
    a_bad_hall_idle: assert property (({hall_a, hall_b, hall_c} == 3'h0 || {hall_a, hall_b, hall_c} == 3'h7) [*6]
        |-> drive.low == 3'h0)
        else $error("low side on with invalid hall code");
    a_restart_unlock: assert property (stop_req [*8] ##1 !stop_req [*4] |-> !speed_locked_n_oe)
        else $error("locked right after leaving stop");

    // Main scenarios reached
    c_lock: cover property ($rose(speed_locked_n_oe));
    c_irq: cover property ($rose(irq));
    c_brake: cover property (drive.high == 3'h7);
    c_chop: cover property (drive.low != 3'h0);
endmodule : servo_monitor

bind bldc_speed_servo_protect servo_monitor mon (
    .clock(clock), .rst(rst), .hall_a(hall_a), .hall_b(hall_b), .hall_c(hall_c),
    .stop_req(stop_req), .over_current(over_current), .drive(drive),
    .speed_locked_n_o(speed_locked_n_o), .speed_locked_n_oe(speed_locked_n_oe), .irq(irq)
);

// [dv/motor_model.sv]
`timescale 1ns/10ps

module motor_model (
    input  wire logic [15:0] tacho_ticks,
    input  wire logic [2:0]  hall_code,
    input  wire logic        overload,
    output logic             osc_in,
    output logic             tacho_pulse,
    output logic             hall_a,
    output logic             hall_b,
    output logic             hall_c,
    output logic             over_current
);
    int ticks;

    // Reference oscillator at 10 MHz, top of the allowed range
    initial
    begin
        osc_in = 1'b0;
        ticks = 0;
        tacho_pulse = 1'b0;
        forever #50 osc_in = ~osc_in;
    end

    // Tacho period in reference ticks; zero means a stalled rotor
    always @(posedge osc_in)
    begin
        if (tacho_ticks == 16'h0)
        begin
            ticks <= 0;
            tacho_pulse <= 1'b0;
        end
        else
        begin
            ticks <= (ticks + 1 >= tacho_ticks) ? 0 : ticks + 1;
            tacho_pulse <= (ticks < tacho_ticks / 2);
        end
    end

    // Hall levels and current comparator
    assign {hall_a, hall_b, hall_c} = hall_code;
    assign over_current = overload;
endmodule : motor_model

// [dv/tb_top.sv]
`timescale 1ns/10ps

module tb_top;
    logic                    clock, rst, we, re, dir_rev, stop_req, stall_timer_input, overload;
    logic                    osc_in, tacho_pulse, hall_a, hall_b, hall_c, over_current;
    logic                    speed_locked_n_o, speed_locked_n_oe, irq;
    logic [7:0]              addr;
    logic [31:0]             wdata, rdata;
    logic [15:0]             tacho_ticks;
    logic [2:0]              hall_code;
    servo_pkg::phase_drive_s drive;
    int                      fails, num_checks, cyc;

    bldc_speed_servo_protect #(.STALL_TMO_DEFAULT(32'h000000c8)) dut (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
        .osc_in(osc_in), .tacho_pulse(tacho_pulse), .hall_a(hall_a), .hall_b(hall_b), .hall_c(hall_c),
        .dir_rev(dir_rev), .stop_req(stop_req), .over_current(over_current),
        .stall_timer_input(stall_timer_input), .drive(drive), .speed_locked_n_o(speed_locked_n_o),
        .speed_locked_n_oe(speed_locked_n_oe), .irq(irq));

    motor_model motor (
        .tacho_ticks(tacho_ticks), .hall_code(hall_code), .overload(overload), .osc_in(osc_in),
        .tacho_pulse(tacho_pulse), .hall_a(hall_a), .hall_b(hall_b), .hall_c(hall_c),
        .over_current(over_current));

    task automatic results;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clock);
        we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        addr <= a;
        re <= 1'b1;
        @(posedge clock);
        re <= 1'b0;
        @(negedge clock);
        v = rdata;
    endtask : rd

    task automatic wait_oe(input logic v, input int lim);
        for (int i = 0; i < lim && speed_locked_n_oe !== v; i++)
            @(negedge clock);
        chk(speed_locked_n_oe, v);
    endtask : wait_oe

    task automatic sweep(input int n, output logic [2:0] lo, output logic [2:0] hi);
        lo = 3'h0;
        hi = 3'h0;
        repeat (n)
        begin
            @(negedge clock);
            lo |= drive.low;
            hi |= drive.high;
        end
    endtask : sweep

    // Forward source phase for a hall code {a,b,c}
    function automatic logic [2:0] src_of(input logic [2:0] h);
        case (h)
            3'h5, 3'h1: src_of = 3'h2;
            3'h4, 3'h6: src_of = 3'h4;
            3'h2, 3'h3: src_of = 3'h1;
            default: src_of = 3'h0;
        endcase
    endfunction : src_of

    task automatic t_regs;
        logic [31:0] v;
        rd(8'h00, v);
        chk(v, 32'h4e2);
        rd(8'h04, v);
        chk(v, 32'hc8);
        rd(8'h08, v);
        chk(v, 32'h1);
        wr(8'h00, 32'h3e8);
        wr(8'h20, 32'hffffffff);
        rd(8'h00, v);
        chk(v, 32'h3e8);
        rd(8'h20, v);
        chk(v, 32'h0);
    endtask : t_regs

    task automatic t_commutation;
        @(posedge clock);
        stop_req <= 1'b0;
        for (int r = 0; r < 2; r++)
            for (int c = 0; c < 8; c++)
            begin
                @(posedge clock);
                hall_code <= c[2:0];
                dir_rev <= r[0];
                repeat (8) @(negedge clock);
                chk(drive.high, r ? src_of(~c[2:0]) : src_of(c[2:0]));
            end
    endtask : t_commutation

    task automatic t_lock;
        logic [31:0] v;
        logic [31:0] d0;
        logic [2:0]  lo;
        logic [2:0]  hi;
        wr(8'h14, 32'h3);
        @(posedge clock);
        hall_code <= 3'h5;
        dir_rev <= 1'b0;
        tacho_ticks <= 16'h21c0;
        wait_oe(1'b1, 50000);
        repeat (3) @(negedge clock);
        chk(irq, 1'b1);
        rd(8'h10, v);
        chk(v, 32'h1);
        wr(8'h10, 32'h1);
        repeat (3) @(negedge clock);
        chk(irq, 1'b0);
        rd(8'h0c, v);
        chk(v > 32'h21be && v < 32'h21c2, 1'b1);
        rd(8'h08, v);
        d0 = v;
        chk({v[31:20] != 12'h0, v[4:0]}, 6'h2a);
        sweep(1000, lo, hi);
        chk({hi, lo}, 6'h11);
        @(posedge clock);
        overload <= 1'b1;
        repeat (20) @(negedge clock);
        sweep(2000, lo, hi);
        chk({hi, lo}, 6'h10);
        rd(8'h08, v);
        chk(v[31:20] < d0[31:20], 1'b1);
        @(posedge clock);
        overload <= 1'b0;
        repeat (4) @(negedge clock);
        wr(8'h10, 32'hf);
    endtask : t_lock

    task automatic t_stall;
        logic [31:0] v;
        @(posedge clock);
        stall_timer_input <= 1'b1;
        tacho_ticks <= 16'h0;
        wait_oe(1'b0, 25000);
        repeat (800) @(negedge clock);
        chk(irq, 1'b1);
        chk(drive, 6'h00);
        rd(8'h08, v);
        chk(v[2:0], 3'h4);
        rd(8'h10, v);
        chk(v, 32'h6);
        @(posedge clock);
        dir_rev <= 1'b1;
        repeat (20) @(negedge clock);
        rd(8'h08, v);
        chk(v[2:0], 3'h4);
        @(posedge clock);
        dir_rev <= 1'b0;
        stop_req <= 1'b1;
        stall_timer_input <= 1'b0;
        repeat (10) @(negedge clock);
        rd(8'h08, v);
        chk(v[2:0], 3'h1);
        wr(8'h10, 32'hf);
        @(posedge clock);
        stop_req <= 1'b0;
        repeat (10) @(negedge clock);
        rd(8'h08, v);
        chk(v[3:0], 4'h2);
    endtask : t_stall

    task automatic t_brake;
        @(posedge clock);
        dir_rev <= 1'b1;
        repeat (8) @(posedge clock);
        overload <= 1'b1;
        repeat (8) @(negedge clock);
        chk(drive, 6'h38);
        @(posedge clock);
        overload <= 1'b0;
        stop_req <= 1'b1;
    endtask : t_brake

    // Clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Hang guard
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            fails++;
            results();
        end
    end

    // Main sequence
    initial
    begin
        cyc = 0;
        rst = 1'b1;
        we = 1'b0;
        re = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        dir_rev = 1'b0;
        stop_req = 1'b1;
        stall_timer_input = 1'b0;
        tacho_ticks = 16'h0;
        hall_code = 3'h5;
        overload = 1'b0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_commutation();
        t_lock();
        t_stall();
        t_brake();
        results();
    end
endmodule : tb_top
